// ---- rtl/ata_task_file_command_decoder.sv ----
// task-file registers, command launch and completion status
module ata_task_file_command_decoder (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// configuration
	input  wire logic              copy_number,
	// host task-file port
	input  wire logic        [2:0] tf_addr,
	input  wire logic              tf_wr,
	input  wire logic              tf_rd,
	input  wire logic        [7:0] tf_wdata,
	output logic             [7:0] tf_rdata,
	output logic                   busy,
	// command launch to media engine
	output logic                   cmd_start,
	output ata_cmd_pkg::cmd_kind_e cmd_kind,
	output logic                   cmd_lba_mode,
	output logic            [27:0] cmd_addr,
	output logic             [7:0] cmd_count,
	output logic             [7:0] cmd_feature,
	// completion from media engine
	input  wire logic              media_done,
	input  wire logic              media_bad_block,
	input  wire logic              media_uncorrectable,
	input  wire logic              media_id_not_found,
	input  wire logic              media_abort,
	input  wire logic              media_corrected,
	input  wire logic              media_drq,
	input  wire logic       [27:0] media_last_addr,
	input  wire logic        [7:0] media_left
);
	import ata_cmd_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_MEDIA} exec_state_e;

	exec_state_e state_ff, nxt_state;
	logic [7:0]  feature_ff, nxt_feature;
	logic [7:0]  count_ff, nxt_count;
	logic [7:0]  secnum_ff, nxt_secnum;
	logic [7:0]  cyl_low_ff, nxt_cyl_low;
	logic [7:0]  cyl_high_ff, nxt_cyl_high;
	logic [7:0]  drv_head_ff, nxt_drv_head;
	logic [7:0]  status_ff, nxt_status;
	logic [7:0]  error_ff, nxt_error;
	logic [7:0]  rdata_ff, nxt_rdata;
	logic        start_ff, nxt_start;
	cmd_kind_e   kind_ff, nxt_kind;
	logic        lba_mode_ff, nxt_lba_mode;
	logic [27:0] addr_ff, nxt_addr;
	logic [7:0]  ccount_ff, nxt_ccount;
	logic [7:0]  cfeat_ff, nxt_cfeat;

	cmd_kind_e   dec_kind;
	logic        dec_supported;
	logic        cmd_write;
	logic        selected;

	opcode_classifier u_classifier (
		.opcode    (tf_wdata),
		.kind      (dec_kind),
		.supported (dec_supported)
	);

	// host writes only take effect while idle
	assign selected  = (drv_head_ff[DH_DRIVE] == copy_number);
	assign cmd_write = tf_wr && (tf_addr == ADDR_STAT_CMD) && (state_ff == ST_IDLE);

	// task-file, status and command launch
	always_comb begin
		nxt_state    = state_ff;
		nxt_feature  = feature_ff;
		nxt_count    = count_ff;
		nxt_secnum   = secnum_ff;
		nxt_cyl_low  = cyl_low_ff;
		nxt_cyl_high = cyl_high_ff;
		nxt_drv_head = drv_head_ff;
		nxt_status   = status_ff;
		nxt_error    = error_ff;
		nxt_start    = 1'b0;
		nxt_kind     = kind_ff;
		nxt_lba_mode = lba_mode_ff;
		nxt_addr     = addr_ff;
		nxt_ccount   = ccount_ff;
		nxt_cfeat    = cfeat_ff;
		case (state_ff)
			ST_IDLE: begin
				if (tf_wr) begin
					case (tf_addr)
						ADDR_ERR_FEAT:  nxt_feature  = tf_wdata;
						ADDR_SEC_COUNT: nxt_count    = tf_wdata;
						ADDR_SEC_NUM:   nxt_secnum   = tf_wdata;
						ADDR_CYL_LOW:   nxt_cyl_low  = tf_wdata;
						ADDR_CYL_HIGH:  nxt_cyl_high = tf_wdata;
						ADDR_DRV_HEAD:  nxt_drv_head = tf_wdata;
						default:        nxt_drv_head = drv_head_ff;
					endcase
				end
				if (cmd_write && selected) begin
					// snapshot of the parameters at the opcode write
					nxt_error    = ERROR_RESET;
					nxt_status   = BUSY_STATUS;
					nxt_kind     = dec_kind;
					nxt_lba_mode = drv_head_ff[DH_LBA];
					nxt_addr     = {drv_head_ff[3:0], cyl_high_ff, cyl_low_ff, secnum_ff};
					nxt_ccount   = count_ff;
					nxt_cfeat    = feature_ff;
					if (!dec_supported || dec_kind == CMD_CHECK_POWER) begin
						nxt_state = ST_LOCAL;
					end else begin
						nxt_state = ST_MEDIA;
						nxt_start = 1'b1;
					end
				end
			end
			ST_LOCAL: begin
				nxt_state          = ST_IDLE;
				nxt_status         = STATUS_RESET;
				if (kind_ff == CMD_NONE) begin
					nxt_error[ER_ABRT] = 1'b1;
					nxt_status[ST_ERR] = 1'b1;
				end else begin
					nxt_count = POWER_IDLE;
				end
			end
			ST_MEDIA: begin
				if (media_done) begin
					nxt_state           = ST_IDLE;
					nxt_error[ER_BBK]   = media_bad_block;
					nxt_error[ER_UNC]   = media_uncorrectable;
					nxt_error[ER_IDNF]  = media_id_not_found;
					nxt_error[ER_ABRT]  = media_abort;
					nxt_status          = STATUS_RESET;
					nxt_status[ST_DRQ]  = media_drq;
					nxt_status[ST_CORR] = media_corrected;
					nxt_status[ST_ERR]  = media_bad_block | media_uncorrectable | media_id_not_found
						| media_abort;
					nxt_drv_head[3:0]   = media_last_addr[27:24];
					nxt_cyl_high        = media_last_addr[23:16];
					nxt_cyl_low         = media_last_addr[15:8];
					nxt_secnum          = media_last_addr[7:0];
					nxt_count           = media_left;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// read data, answered one cycle after the strobe
	always_comb begin
		nxt_rdata = rdata_ff;
		if (tf_rd) begin
			case (tf_addr)
				ADDR_ERR_FEAT:  nxt_rdata = error_ff;
				ADDR_SEC_COUNT: nxt_rdata = count_ff;
				ADDR_SEC_NUM:   nxt_rdata = secnum_ff;
				ADDR_CYL_LOW:   nxt_rdata = cyl_low_ff;
				ADDR_CYL_HIGH:  nxt_rdata = cyl_high_ff;
				ADDR_DRV_HEAD:  nxt_rdata = drv_head_ff;
				ADDR_STAT_CMD:  nxt_rdata = status_ff;
				default:        nxt_rdata = TF_RESET;
			endcase
		end
	end

	// task-file and command snapshot registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_ff    <= ST_IDLE;
			feature_ff  <= TF_RESET;
			count_ff    <= COUNT_RESET;
			secnum_ff   <= COUNT_RESET;
			cyl_low_ff  <= TF_RESET;
			cyl_high_ff <= TF_RESET;
			drv_head_ff <= DH_RESET;
			status_ff   <= STATUS_RESET;
			error_ff    <= ERROR_RESET;
			start_ff    <= 1'b0;
			kind_ff     <= CMD_NONE;
			lba_mode_ff <= 1'b0;
			addr_ff     <= '0;
			ccount_ff   <= TF_RESET;
			cfeat_ff    <= TF_RESET;
		end else begin
			state_ff    <= nxt_state;
			feature_ff  <= nxt_feature;
			count_ff    <= nxt_count;
			secnum_ff   <= nxt_secnum;
			cyl_low_ff  <= nxt_cyl_low;
			cyl_high_ff <= nxt_cyl_high;
			drv_head_ff <= nxt_drv_head;
			status_ff   <= nxt_status;
			error_ff    <= nxt_error;
			start_ff    <= nxt_start;
			kind_ff     <= nxt_kind;
			lba_mode_ff <= nxt_lba_mode;
			addr_ff     <= nxt_addr;
			ccount_ff   <= nxt_ccount;
			cfeat_ff    <= nxt_cfeat;
		end
	end

	// read data register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_ff <= TF_RESET;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// outputs straight from flip-flops
	assign tf_rdata     = rdata_ff;
	assign busy         = status_ff[ST_BUSY];
	assign cmd_start    = start_ff;
	assign cmd_kind     = kind_ff;
	assign cmd_lba_mode = lba_mode_ff;
	assign cmd_addr     = addr_ff;
	assign cmd_count    = ccount_ff;
	assign cmd_feature  = cfeat_ff;
endmodule : ata_task_file_command_decoder

// ---- rtl/ata_cmd_pkg.sv ----
// constants and types of the task-file command decoder
package ata_cmd_pkg;
	// task-file register addresses
	localparam logic [2:0] ADDR_ERR_FEAT  = 3'h1;
	localparam logic [2:0] ADDR_SEC_COUNT = 3'h2;
	localparam logic [2:0] ADDR_SEC_NUM   = 3'h3;
	localparam logic [2:0] ADDR_CYL_LOW   = 3'h4;
	localparam logic [2:0] ADDR_CYL_HIGH  = 3'h5;
	localparam logic [2:0] ADDR_DRV_HEAD  = 3'h6;
	localparam logic [2:0] ADDR_STAT_CMD  = 3'h7;
	// status bit positions
	localparam int ST_BUSY  = 7;
	localparam int ST_RDY   = 6;
	localparam int ST_FAULT = 5;
	localparam int ST_SEEK  = 4;
	localparam int ST_DRQ   = 3;
	localparam int ST_CORR  = 2;
	localparam int ST_INDEX = 1;
	localparam int ST_ERR   = 0;
	// error bit positions
	localparam int ER_BBK  = 7;
	localparam int ER_UNC  = 6;
	localparam int ER_IDNF = 4;
	localparam int ER_ABRT = 2;
	// drive/head field positions
	localparam int DH_LBA   = 6;
	localparam int DH_DRIVE = 4;
	// reset values, launch busy status and check-power count
	localparam logic [7:0] STATUS_RESET = 8'h50;
	localparam logic [7:0] ERROR_RESET  = 8'h00;
	localparam logic [7:0] TF_RESET     = 8'h00;
	localparam logic [7:0] COUNT_RESET  = 8'h01;
	localparam logic [7:0] DH_RESET     = 8'ha0;
	localparam logic [7:0] POWER_IDLE   = 8'hff;
	localparam logic [7:0] BUSY_STATUS  = 8'h80;
	// opcodes
	localparam logic [7:0] OP_RD_A = 8'h20, OP_RD_B = 8'h21, OP_RDL_A = 8'h22, OP_RDL_B = 8'h23;
	localparam logic [7:0] OP_WR_A = 8'h30, OP_WR_B = 8'h31, OP_WRL_A = 8'h32, OP_WRL_B = 8'h33;
	localparam logic [7:0] OP_WR_NE = 8'h38, OP_WR_VFY = 8'h3c, OP_VFY_A = 8'h40, OP_VFY_B = 8'h41;
	localparam logic [7:0] OP_RD_MULT = 8'hc4, OP_WR_MULT = 8'hc5, OP_WR_MULT_NE = 8'hcd;
	localparam logic [7:0] OP_SET_MULT = 8'hc6, OP_ERASE = 8'hc0, OP_FORMAT = 8'h50, OP_SENSE = 8'h03;
	localparam logic [7:0] OP_CHK_A = 8'h98, OP_CHK_B = 8'he5, OP_SLP_A = 8'h99, OP_SLP_B = 8'he6;
	localparam logic [7:0] OP_STB_A = 8'h96, OP_STB_B = 8'he2, OP_STBI_A = 8'h94, OP_STBI_B = 8'he0;
	localparam logic [7:0] OP_IDL_A = 8'h97, OP_IDL_B = 8'he3, OP_IDLI_A = 8'h95, OP_IDLI_B = 8'he1;
	localparam logic [7:0] OP_DIAG = 8'h90, OP_INIT_PARAM = 8'h91, OP_IDENT = 8'hec, OP_SET_FEAT = 8'hef;
	localparam logic [7:0] OP_RD_BUF = 8'he4, OP_WR_BUF = 8'he8, OP_XLATE = 8'h87, OP_WEAR = 8'hf5;
	localparam logic [3:0] OP_RECAL_HI = 4'h1;
	localparam logic [3:0] OP_SEEK_HI  = 4'h7;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_READ, CMD_WRITE, CMD_READ_MULT, CMD_WRITE_MULT_NE, CMD_WRITE_NE,
		CMD_CHECK_POWER, CMD_SLEEP, CMD_STANDBY, CMD_RECAL, CMD_SEEK, CMD_IDENTIFY, CMD_OTHER
	} cmd_kind_e;
endpackage : ata_cmd_pkg

// ---- rtl/opcode_classifier.sv ----
// maps a command opcode onto a command kind
module opcode_classifier (
	// opcode in
	input  wire logic        [7:0] opcode,
	// kind out
	output ata_cmd_pkg::cmd_kind_e kind,
	output logic                   supported
);
	import ata_cmd_pkg::*;

	always_comb begin
		kind = CMD_NONE;
		case (opcode)
			OP_RD_A, OP_RD_B:             kind = CMD_READ;
			OP_WR_A, OP_WR_B:             kind = CMD_WRITE;
			OP_RD_MULT:                   kind = CMD_READ_MULT;
			OP_WR_MULT_NE:                kind = CMD_WRITE_MULT_NE;
			OP_WR_NE:                     kind = CMD_WRITE_NE;
			OP_CHK_A, OP_CHK_B:           kind = CMD_CHECK_POWER;
			OP_SLP_A, OP_SLP_B:           kind = CMD_SLEEP;
			OP_STB_A, OP_STB_B:           kind = CMD_STANDBY;
			OP_IDENT:                     kind = CMD_IDENTIFY;
			OP_RDL_A, OP_RDL_B, OP_WRL_A, OP_WRL_B, OP_WR_VFY, OP_VFY_A, OP_VFY_B,
			OP_WR_MULT, OP_SET_MULT, OP_ERASE, OP_FORMAT, OP_SENSE, OP_STBI_A, OP_STBI_B,
			OP_IDL_A, OP_IDL_B, OP_IDLI_A, OP_IDLI_B, OP_DIAG, OP_INIT_PARAM, OP_SET_FEAT,
			OP_RD_BUF, OP_WR_BUF, OP_XLATE, OP_WEAR: kind = CMD_OTHER;
			default: begin
				if (opcode[7:4] == OP_RECAL_HI) begin
					kind = CMD_RECAL;
				end else if (opcode[7:4] == OP_SEEK_HI) begin
					kind = CMD_SEEK;
				end else begin
					kind = CMD_NONE;
				end
			end
		endcase
	end

	assign supported = (kind != CMD_NONE);
endmodule : opcode_classifier

// ---- dv/tf_cmd_checker_sva.sv ----
// port assertions for the task-file command decoder
module tf_cmd_checker
	import ata_cmd_pkg::*;
(
	// watched ports
	input wire logic                      core_clk, nrst, tf_wr, tf_rd, busy, cmd_start, media_done,
	input wire logic                [2:0] tf_addr,
	input wire logic                [7:0] tf_wdata, tf_rdata,
	input wire ata_cmd_pkg::cmd_kind_e    cmd_kind
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	logic [7:0] op_ff;
	always_ff @(posedge core_clk) op_ff <= tf_wdata;
	start_busy_a: assert property (cmd_start |-> busy ##[1:40] !busy) else $error("busy unbounded");
	start_cause_a: assert property (cmd_start |-> $past(tf_wr && tf_addr == 3'h7 && !busy)) else $error("stray start");
	read_kind_a: assert property (cmd_start |-> (op_ff inside {8'h20, 8'h21}) == (cmd_kind == CMD_READ))
		else $error("read kind");
	xfer_kind_a: assert property (cmd_start |-> ((op_ff == 8'hc4) == (cmd_kind == CMD_READ_MULT))
		&& ((op_ff inside {8'h30, 8'h31}) == (cmd_kind == CMD_WRITE))) else $error("transfer kind");
	noerase_kind_a: assert property (cmd_start |-> ((op_ff == 8'hcd) == (cmd_kind == CMD_WRITE_MULT_NE))
		&& ((op_ff == 8'h38) == (cmd_kind == CMD_WRITE_NE))) else $error("no-erase kind");
	nibble_kind_a: assert property (cmd_start |-> ((op_ff[7:4] == 4'h1) == (cmd_kind == CMD_RECAL))
		&& ((op_ff[7:4] == 4'h7) == (cmd_kind == CMD_SEEK))) else $error("nibble kind");
	power_kind_a: assert property (cmd_start |-> ((op_ff inside {8'h99, 8'he6}) == (cmd_kind == CMD_SLEEP))
		&& ((op_ff inside {8'h96, 8'he2}) == (cmd_kind == CMD_STANDBY))) else $error("power kind");
	local_done_a: assert property (tf_wr && tf_addr == 3'h7 && !busy && tf_wdata inside {8'h98, 8'he5}
		|=> !cmd_start ##1 !busy) else $error("check power");
	done_idle_a: assert property (busy && media_done && !cmd_start |=> !busy) else $error("done ignored");
	hold_kind_a: assert property (busy |=> $stable(cmd_kind) && !cmd_start) else $error("restart");
	status_fix_a: assert property (tf_rd && tf_addr == 3'h7 && !busy |=> tf_rdata[7:4] == 4'h5 && !tf_rdata[1])
		else $error("status bits");
	error_zero_a: assert property (tf_rd && tf_addr == 3'h1 |=> (tf_rdata & 8'h2b) == 8'h00)
		else $error("error bits");
	cover property (cmd_start && cmd_kind == CMD_WRITE_NE);
	cover property (busy && media_done);
	cover property (tf_wr && tf_addr == 3'h7 && busy);
endmodule : tf_cmd_checker
bind ata_task_file_command_decoder tf_cmd_checker chk_i (.core_clk, .nrst, .tf_wr, .tf_rd, .busy, .cmd_start,
	.media_done, .tf_addr, .tf_wdata, .tf_rdata, .cmd_kind);

// ---- dv/media_model.sv ----
// media engine model answering launched commands after a set delay
module media_model (
	// control
	input wire logic         core_clk, nrst, cmd_start,
	input wire logic  [27:0] cmd_addr,
	input wire logic   [7:0] cmd_count, m_delay,
	input wire logic   [5:0] m_flags,
	// answer
	output logic             media_done = 1'b0,
	output logic       [5:0] m_out = '0,
	output logic      [27:0] media_last_addr = '0,
	output logic       [7:0] media_left = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic  [7:0] cnt = '0, n;
	logic [27:0] a;
	// outcome lines only hold meaning in the done cycle
	always @(posedge core_clk) begin
		media_done <= 1'b0;
		m_out <= 6'($urandom);
		media_last_addr <= 28'($urandom);
		media_left <= 8'($urandom);
		if (!nrst) cnt <= '0;
		else if (cmd_start) begin
			cnt <= m_delay;
			a <= cmd_addr;
			n <= cmd_count;
		end else if (cnt != 8'h0) begin
			cnt <= cnt - 8'h1;
			if (cnt == 8'h1) begin
				media_done <= 1'b1;
				m_out <= m_flags;
				media_last_addr <= |m_flags[5:2] ? a : a + 28'(n) - 28'h1;
				media_left <= |m_flags[5:2] ? n : 8'h0;
			end
		end
	end
endmodule : media_model

// ---- dv/tb.sv ----
// self-checking bench for the task-file command decoder
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ata_cmd_pkg::*;
	logic        core_clk = 1'b0, nrst = 1'b0, copy_number = 1'b0, tf_wr = 1'b0, tf_rd = 1'b0;
	logic        busy, cmd_start, cmd_lba_mode, media_done;
	logic  [2:0] tf_addr = '0;
	logic  [7:0] tf_wdata = '0, m_delay = '0, tf_rdata, cmd_count, cmd_feature, media_left;
	logic  [5:0] m_flags = '0, m_out;
	logic [27:0] cmd_addr, media_last_addr;
	cmd_kind_e   cmd_kind;
	int          n_fail = 0, total_checks = 0;
	logic  [7:0] rv [1:7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h50};
	logic  [7:0] ops [19] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hc4, 8'hcd, 8'h38, 8'h10, 8'h7f, 8'hec, 8'h99, 8'he6,
		8'h96, 8'he2, 8'hef, 8'h98, 8'he5, 8'h00, 8'hff};
	cmd_kind_e   kinds [19] = '{CMD_READ, CMD_READ, CMD_WRITE, CMD_WRITE, CMD_READ_MULT, CMD_WRITE_MULT_NE,
		CMD_WRITE_NE, CMD_RECAL, CMD_SEEK, CMD_IDENTIFY, CMD_SLEEP, CMD_SLEEP, CMD_STANDBY, CMD_STANDBY,
		CMD_OTHER, CMD_CHECK_POWER, CMD_CHECK_POWER, CMD_NONE, CMD_NONE};
	always #50 core_clk = ~core_clk;
	ata_task_file_command_decoder uut (.core_clk, .nrst, .copy_number, .tf_addr, .tf_wr, .tf_rd, .tf_wdata,
		.tf_rdata, .busy, .cmd_start, .cmd_kind, .cmd_lba_mode, .cmd_addr, .cmd_count, .cmd_feature, .media_done,
		.media_bad_block(m_out[5]), .media_uncorrectable(m_out[4]), .media_id_not_found(m_out[3]),
		.media_abort(m_out[2]), .media_drq(m_out[1]), .media_corrected(m_out[0]), .media_last_addr, .media_left);
	media_model partner (.core_clk, .nrst, .cmd_start, .cmd_addr, .cmd_count, .m_delay, .m_flags, .media_done,
		.m_out, .media_last_addr, .media_left);
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge core_clk);
		tf_wr <= 1'b1;
		tf_addr <= a;
		tf_wdata <= d;
		@(posedge core_clk);
		tf_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		tf_rd <= 1'b1;
		tf_addr <= a;
		@(posedge core_clk);
		tf_rd <= 1'b0;
		@(posedge core_clk);
		#1 d = tf_rdata;
	endtask : rd
	task automatic wait_idle;
		#1;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (busy !== 1'b0) begin
			n_fail++;
			final_report;
		end
	endtask : wait_idle
	// status in the upper byte, error in the lower
	function automatic logic [15:0] outcome(logic [5:0] f);
		return {4'h5, f[1], f[0], 1'b0, |f[5:2], f[5], f[4], 1'b0, f[3], 1'b0, f[2], 2'b00};
	endfunction : outcome
	task automatic run(logic [7:0] op, cmd_kind_e k, bit sel);
		logic  [7:0] dh, sc, sn, cl, ch, ft, d, en, dl;
		logic [15:0] se;
		logic [27:0] a, ea;
		logic  [5:0] f;
		bit          c, lc;
		c = 1'($urandom);
		lc = k inside {CMD_CHECK_POWER, CMD_NONE};
		if (op[7:4] inside {4'h1, 4'h7}) op[3:0] = 4'($urandom);
		{dh, sc, sn, cl, ch, ft} = {$urandom, 16'($urandom)};
		{dh[7], dh[5]} = 2'b11;
		dh[4] = c ^ !sel;
		f = 6'($urandom);
		if ($urandom % 2 == 0) f[5:2] = 4'h0;
		dl = ($urandom % 3 == 0) ? 8'h1 : 8'h8 + 8'($urandom % 8);
		@(posedge core_clk);
		copy_number <= c;
		m_flags <= f;
		m_delay <= dl;
		wr(3'h1, ft);
		wr(3'h2, sc);
		wr(3'h3, sn);
		wr(3'h4, cl);
		wr(3'h5, ch);
		wr(3'h6, dh);
		wr(3'h7, op);
		#1;
		a = {dh[3:0], ch, cl, sn};
		if (!sel) begin
			chk("ignored", {busy, cmd_start}, 0);
			return;
		end
		chk("launch", {busy, cmd_start}, {1'b1, !lc});
		if (lc) begin
			se = k == CMD_NONE ? 16'h5104 : 16'h5000;
			ea = a;
			en = k == CMD_NONE ? sc : 8'hff;
		end else begin
			chk("kind", cmd_kind, k);
			chk("addr", cmd_addr, a);
			chk("count", cmd_count, sc);
			chk("feature", cmd_feature, ft);
			chk("lba", cmd_lba_mode, dh[6]);
			se = outcome(f);
			ea = |f[5:2] ? a : a + 28'(sc) - 28'h1;
			en = |f[5:2] ? sc : 8'h0;
			if (dl > 8'h7) begin
				rd(3'h1, d);
				chk("err_clear", d, 0);
				wr(3'h7, 8'h20);
			end
		end
		wait_idle;
		if (!lc) chk("kind_hold", cmd_kind, k);
		rd(3'h7, d);
		chk("status", d, se[15:8]);
		rd(3'h1, d);
		chk("error", d, se[7:0]);
		rd(3'h2, d);
		chk("left", d, en);
		for (int i = 3; i < 7; i++) begin
			rd(3'(i), d);
			chk("address", i == 6 ? d & 8'h0f : d, 8'(ea >> (8 * (i - 3))));
		end
	endtask : run
	initial begin
		logic [7:0] d;
		int         j;
		void'($urandom(32'hfbed));
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 1; i < 8; i++) begin
			rd(3'(i), d);
			chk("reset", d, rv[i]);
		end
		foreach (ops[i]) run(ops[i], kinds[i], 1'b1);
		run(8'h20, CMD_READ, 1'b0);
		repeat (60) begin
			j = $urandom % 19;
			run(ops[j], kinds[j], $urandom % 8 != 0);
		end
		final_report;
	end
endmodule : tb
